// File: cltd_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - 11100ccc plus 8-bit offset: conditional branch on Z/C/OV/N, 1 cycle, 2 taken
// - Absolute call: 1110110s word, then 1111 word, 20-bit target, s passed on
// - Absolute jump: 11101111 word, then 1111 word, 20-bit target, two cycles
// - A lone word with top nibble 1111 executes as no-operation
// - Program counter change by a one-word op or true test adds a second, no-operation cycle
// - 0x0006 pops, 0x0005 pushes return stack, one cycle, no flags
// - 0x0010/11 interrupt return updates enables, 0x0012/13 return, two cycles
// - 0x0ckk returns with literal into working register, two cycles, no flags
// - 0x0003 standby, 0x0004 watchdog clear, one cycle, update time-out/power-down
// - Literal add and literal subtract, one cycle, update all five flags
// - Literal AND, OR, XOR, one cycle, update zero and negative only
// - 0x0ekk loads literal into working register, one cycle, no flags
// - 0x0dkk multiplies literal by working register, one cycle, no flags
// - 0x010k loads four bits into bank select register, one cycle
// - Pointer load: 11101110 00ff kkkk then 11110000 kkkkkkkk, 12-bit literal
// - 0x0008-0x000b table read, two cycles, low bits give pointer mode
// - 0x000c-0x000f table write, two cycles, five when memory write starts
// - A started internal memory write runs until terminated, not with instruction
// - Port read-modify-write takes pin levels, not output latch
// - Marked ops on timer zero count with no destination or a file destination clear prescaler when assigned to it
module cltd_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Instruction fetch
    input wire logic [15:0] instrWord,
    input wire logic instrValid,
    // Core status flags
    input wire cltd_pkg::cltd_flags_t statusFlags,
    // Internal memory write handshake
    input wire logic writeCycleStart,
    input wire logic writeCycleDone,
    // Port read-modify-write
    input wire logic rmwTargetIsPort,
    input wire logic [7:0] portPinLevels,
    input wire logic [7:0] portLatchValue,
    // Timer zero side effect
    input wire logic fileOpMarked,
    input wire logic fileOpTargetsTimer,
    input wire logic fileOpNeedsDest,
    input wire logic fileOpDestIsFile,
    input wire logic prescalerOnTimer,
    // Decoded control
    output cltd_pkg::cltd_ctrl_t ctrl_r,
    output logic ctrlValid_r,
    output logic nopCycle_r,
    output logic writeBusy_r,
    output logic [7:0] rmwSource_r,
    output logic prescalerClear_r
);

    function automatic cltd_pkg::cltd_op_t decodeOp(input logic [15:0] w);
        cltd_pkg::cltd_op_t op;
        op = cltd_pkg::OP_NOP;
        if (w[15:11] == cltd_pkg::ENC_COND_BR) begin
            op = cltd_pkg::OP_BRANCH;
        end else if (w[15:11] == cltd_pkg::ENC_REL_JUMP) begin
            op = cltd_pkg::OP_REL_JUMP;
        end else if (w[15:11] == cltd_pkg::ENC_REL_CALL) begin
            op = cltd_pkg::OP_REL_CALL;
        end else if (w[15:9] == cltd_pkg::ENC_ABS_CALL) begin
            op = cltd_pkg::OP_ABS_CALL;
        end else if (w[15:8] == cltd_pkg::ENC_ABS_JUMP) begin
            op = cltd_pkg::OP_ABS_JUMP;
        end else if (w[15:6] == cltd_pkg::ENC_PTR_LOAD) begin
            op = cltd_pkg::OP_PTR_LOAD;
        end else if (w[15:12] == cltd_pkg::ENC_DATA_WORD) begin
            op = cltd_pkg::OP_NOP;
        end else if (w[15:4] == cltd_pkg::ENC_BANK_LOAD) begin
            op = cltd_pkg::OP_BANK_LOAD;
        end else if (w[15:8] == cltd_pkg::ENC_ZERO_HI) begin
            if (w[7:2] == cltd_pkg::ENC_TBL_READ) begin
                op = cltd_pkg::OP_TBL_READ;
            end else if (w[7:2] == cltd_pkg::ENC_TBL_WRITE) begin
                op = cltd_pkg::OP_TBL_WRITE;
            end else if (w[7:1] == cltd_pkg::ENC_INT_RET) begin
                op = cltd_pkg::OP_INT_RET;
            end else if (w[7:1] == cltd_pkg::ENC_SUB_RET) begin
                op = cltd_pkg::OP_SUB_RET;
            end else begin
                case (w[7:0])
                    cltd_pkg::ENC_SLEEP: op = cltd_pkg::OP_SLEEP;
                    cltd_pkg::ENC_WDT_CLR: op = cltd_pkg::OP_WDT_CLR;
                    cltd_pkg::ENC_PUSH: op = cltd_pkg::OP_PUSH;
                    cltd_pkg::ENC_POP: op = cltd_pkg::OP_POP;
                    cltd_pkg::ENC_DEC_ADJ: op = cltd_pkg::OP_DEC_ADJ;
                    cltd_pkg::ENC_SW_RESET: op = cltd_pkg::OP_SW_RESET;
                    default: op = cltd_pkg::OP_NOP;
                endcase
            end
        end else begin
            case (w[15:8])
                cltd_pkg::ENC_LIT_ADD: op = cltd_pkg::OP_LIT_ADD;
                cltd_pkg::ENC_LIT_SUB: op = cltd_pkg::OP_LIT_SUB;
                cltd_pkg::ENC_LIT_AND: op = cltd_pkg::OP_LIT_AND;
                cltd_pkg::ENC_LIT_OR: op = cltd_pkg::OP_LIT_OR;
                cltd_pkg::ENC_LIT_XOR: op = cltd_pkg::OP_LIT_XOR;
                cltd_pkg::ENC_LIT_LOAD: op = cltd_pkg::OP_LIT_LOAD;
                cltd_pkg::ENC_LIT_MUL: op = cltd_pkg::OP_LIT_MUL;
                cltd_pkg::ENC_LIT_RET: op = cltd_pkg::OP_LIT_RET;
                default: op = cltd_pkg::OP_NOP;
            endcase
        end
        return op;
    endfunction : decodeOp

    function automatic cltd_pkg::cltd_flags_t flagsOf(input cltd_pkg::cltd_op_t op);
        cltd_pkg::cltd_flags_t mask;
        mask = cltd_pkg::FLAGS_NONE;
        if (op == cltd_pkg::OP_LIT_ADD || op == cltd_pkg::OP_LIT_SUB) begin
            mask = cltd_pkg::FLAGS_ALL;
        end else if (op == cltd_pkg::OP_SW_RESET) begin
            mask = cltd_pkg::FLAGS_ALL;
        end else if (op == cltd_pkg::OP_DEC_ADJ) begin
            mask = cltd_pkg::FLAGS_CARRY;
        end else if (op == cltd_pkg::OP_LIT_AND || op == cltd_pkg::OP_LIT_OR
                     || op == cltd_pkg::OP_LIT_XOR) begin
            mask = cltd_pkg::FLAGS_LOGIC;
        end
        return mask;
    endfunction : flagsOf

    cltd_pkg::cltd_state_t state_r, state_nxt;
    logic [15:0] firstWord_r, firstWord_nxt;
    logic [2:0] holdCnt_r, holdCnt_nxt;
    logic longWrite_r, longWrite_nxt;
    cltd_pkg::cltd_ctrl_t ctrl_nxt;
    logic ctrlValid_nxt;
    logic nopCycle_nxt;
    logic writeBusy_nxt;
    logic prescalerClear_nxt;

    // Decode of the fetched word and of a held first word
    cltd_pkg::cltd_op_t curOp;
    cltd_pkg::cltd_op_t firstOp;
    cltd_pkg::cltd_op_t execOp;
    logic condTaken;
    logic inExec;
    logic inWord2;
    logic twoWordFirst;
    logic isReturn;
    logic pcChange;
    logic needFlush;
    logic startsWrite;

    assign curOp = decodeOp(instrWord);
    assign firstOp = decodeOp(firstWord_r);
    assign inExec = (state_r == cltd_pkg::ST_EXEC) && instrValid;
    assign inWord2 = (state_r == cltd_pkg::ST_WORD2) && instrValid;
    assign execOp = inWord2 ? firstOp : curOp;

    cltd_cond_eval u_cond (
        .condCode(instrWord[10:8]),
        .flags(statusFlags),
        .taken(condTaken)
    );

    assign twoWordFirst = curOp == cltd_pkg::OP_ABS_CALL || curOp == cltd_pkg::OP_ABS_JUMP
                          || curOp == cltd_pkg::OP_PTR_LOAD;
    assign isReturn = curOp == cltd_pkg::OP_INT_RET || curOp == cltd_pkg::OP_SUB_RET
                      || curOp == cltd_pkg::OP_LIT_RET;
    assign pcChange = (curOp == cltd_pkg::OP_BRANCH && condTaken)
                      || curOp == cltd_pkg::OP_REL_JUMP || curOp == cltd_pkg::OP_REL_CALL
                      || isReturn;
    assign needFlush = pcChange || curOp == cltd_pkg::OP_TBL_READ
                       || curOp == cltd_pkg::OP_TBL_WRITE;
    assign startsWrite = inExec && curOp == cltd_pkg::OP_TBL_WRITE && writeCycleStart;

    // Sequencing of second words, no-operation cycles and long table writes
    always_comb begin
        state_nxt = state_r;
        firstWord_nxt = firstWord_r;
        holdCnt_nxt = holdCnt_r;
        longWrite_nxt = longWrite_r;
        unique case (state_r)
            cltd_pkg::ST_EXEC: begin
                if (instrValid && twoWordFirst) begin
                    state_nxt = cltd_pkg::ST_WORD2;
                    firstWord_nxt = instrWord;
                end else if (instrValid && needFlush) begin
                    state_nxt = cltd_pkg::ST_FLUSH;
                    longWrite_nxt = startsWrite;
                end
            end
            cltd_pkg::ST_WORD2: begin
                if (instrValid) begin
                    state_nxt = cltd_pkg::ST_EXEC;
                end
            end
            cltd_pkg::ST_FLUSH: begin
                if (instrValid && longWrite_r) begin
                    state_nxt = cltd_pkg::ST_HOLD;
                    holdCnt_nxt = cltd_pkg::HOLD_CYCLES;
                    longWrite_nxt = 1'b0;
                end else if (instrValid) begin
                    state_nxt = cltd_pkg::ST_EXEC;
                end
            end
            cltd_pkg::ST_HOLD: begin
                holdCnt_nxt = holdCnt_r - 3'h1;
                if (holdCnt_r == 3'h1) begin
                    state_nxt = cltd_pkg::ST_EXEC;
                end
            end
        endcase
    end

    // Control word for the core datapath
    always_comb begin
        ctrl_nxt = '0;
        ctrl_nxt.op = execOp;
        ctrl_nxt.flagUpd = flagsOf(execOp);
        ctrl_nxt.literal = instrWord[7:0];
        ctrl_nxt.tableMode = instrWord[1:0];
        ctrl_nxt.fastReturn = instrWord[0];
        ctrl_nxt.toPdUpd = execOp == cltd_pkg::OP_SLEEP
                           || execOp == cltd_pkg::OP_WDT_CLR;
        ctrl_nxt.intEnUpd = execOp == cltd_pkg::OP_INT_RET;
        if (execOp == cltd_pkg::OP_BANK_LOAD) begin
            ctrl_nxt.literal = {4'h0, instrWord[3:0]};
        end
        if (execOp == cltd_pkg::OP_BRANCH) begin
            ctrl_nxt.relOffset = {{3{instrWord[7]}}, instrWord[7:0]};
        end else begin
            ctrl_nxt.relOffset = instrWord[10:0];
        end
        if (inWord2) begin
            ctrl_nxt.absTarget = {instrWord[11:0], firstWord_r[7:0]};
            ctrl_nxt.fastReturn = firstWord_r[8];
            ctrl_nxt.pointerSel = firstWord_r[5:4];
            ctrl_nxt.pointerLit = {firstWord_r[3:0], instrWord[7:0]};
            ctrl_nxt.pcLoad = firstOp != cltd_pkg::OP_PTR_LOAD;
        end else begin
            ctrl_nxt.pcLoad = pcChange;
        end
    end

    assign ctrlValid_nxt = (inExec && !twoWordFirst) || inWord2;
    assign nopCycle_nxt = ((state_r == cltd_pkg::ST_FLUSH) && instrValid)
                          || state_r == cltd_pkg::ST_HOLD;
    // A new start wins over a termination in the same cycle
    assign writeBusy_nxt = startsWrite || (writeBusy_r && !writeCycleDone);
    assign prescalerClear_nxt = fileOpMarked && fileOpTargetsTimer && prescalerOnTimer
                                && (!fileOpNeedsDest || fileOpDestIsFile);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= cltd_pkg::ST_EXEC;
            firstWord_r <= 16'h0000;
            holdCnt_r <= 3'h0;
            longWrite_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            firstWord_r <= firstWord_nxt;
            holdCnt_r <= holdCnt_nxt;
            longWrite_r <= longWrite_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= '0;
            ctrlValid_r <= 1'b0;
            nopCycle_r <= 1'b0;
            writeBusy_r <= 1'b0;
            rmwSource_r <= 8'h00;
            prescalerClear_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            ctrlValid_r <= ctrlValid_nxt;
            nopCycle_r <= nopCycle_nxt;
            writeBusy_r <= writeBusy_nxt;
            rmwSource_r <= rmwTargetIsPort ? portPinLevels : portLatchValue;
            prescalerClear_r <= prescalerClear_nxt;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_absFirst;
        inExec && (curOp == cltd_pkg::OP_ABS_CALL || curOp == cltd_pkg::OP_ABS_JUMP);
    endsequence

    sequence s_longWrite;
        startsWrite ##1 instrValid;
    endsequence

    cond_taken_flush_a: assert property (
        inExec && curOp == cltd_pkg::OP_BRANCH && condTaken
        |=> state_r == cltd_pkg::ST_FLUSH && ctrl_r.pcLoad && ctrlValid_r)
        else $error("taken branch did not load pc and flush");

    cond_not_taken_a: assert property (
        inExec && curOp == cltd_pkg::OP_BRANCH && !condTaken
        |=> state_r == cltd_pkg::ST_EXEC && !ctrl_r.pcLoad)
        else $error("untaken branch spent a second cycle");

    rel_branch_two_a: assert property (
        inExec && (curOp == cltd_pkg::OP_REL_JUMP || curOp == cltd_pkg::OP_REL_CALL)
        |=> (ctrl_r.pcLoad && ctrl_r.relOffset == $past(instrWord[10:0])
            && state_r == cltd_pkg::ST_FLUSH) and (instrValid |=> nopCycle_r))
        else $error("relative branch not two cycles");

    abs_target_a: assert property (
        s_absFirst ##1 instrValid
        |=> ctrlValid_r && ctrl_r.pcLoad
            && ctrl_r.absTarget[7:0] == $past(instrWord[7:0], 2)
            && ctrl_r.absTarget[19:8] == $past(instrWord[11:0]))
        else $error("absolute target assembled wrongly");

    data_word_nop_a: assert property (
        inExec && instrWord[15:12] == cltd_pkg::ENC_DATA_WORD
        |=> ctrlValid_r && ctrl_r.op == cltd_pkg::OP_NOP && !ctrl_r.pcLoad
            && state_r == cltd_pkg::ST_EXEC)
        else $error("lone data word did not execute as nop");

    stack_one_cycle_a: assert property (
        inExec && (curOp == cltd_pkg::OP_POP || curOp == cltd_pkg::OP_PUSH)
        |=> state_r == cltd_pkg::ST_EXEC && ctrl_r.flagUpd == cltd_pkg::FLAGS_NONE)
        else $error("stack op took extra cycle or flags");

    logic_flags_a: assert property (
        inExec && (curOp == cltd_pkg::OP_LIT_AND || curOp == cltd_pkg::OP_LIT_XOR
            || curOp == cltd_pkg::OP_LIT_OR)
        |=> ctrl_r.flagUpd == cltd_pkg::FLAGS_LOGIC)
        else $error("logic literal flag mask wrong");

    tbl_write_long_a: assert property (
        s_longWrite |=> nopCycle_r [*3] ##1 (nopCycle_r && state_r == cltd_pkg::ST_EXEC))
        else $error("long table write not five cycles");

    write_busy_hold_a: assert property (
        writeBusy_r && !writeCycleDone && state_r == cltd_pkg::ST_EXEC |=> writeBusy_r)
        else $error("internal write ended with instruction");

    rmw_pin_source_a: assert property (
        rmwTargetIsPort |=> rmwSource_r == $past(portPinLevels))
        else $error("rmw source not taken from pins");

    prescaler_clear_a: assert property (
        prescalerClear_r == $past(fileOpTargetsTimer && prescalerOnTimer && fileOpMarked
            && (!fileOpNeedsDest || fileOpDestIsFile)))
        else $error("prescaler cleared without cause");

endmodule : cltd_decoder

// File: cltd_pkg.sv
package cltd_pkg;

    // Upper-bit patterns of the control group
    localparam logic [4:0] ENC_COND_BR = 5'h1c;
    localparam logic [4:0] ENC_REL_JUMP = 5'h1a;
    localparam logic [4:0] ENC_REL_CALL = 5'h1b;
    localparam logic [6:0] ENC_ABS_CALL = 7'h76;
    localparam logic [7:0] ENC_ABS_JUMP = 8'hef;
    localparam logic [9:0] ENC_PTR_LOAD = 10'h3b8;
    localparam logic [3:0] ENC_DATA_WORD = 4'hf;
    localparam logic [7:0] ENC_ZERO_HI = 8'h00;
    localparam logic [11:0] ENC_BANK_LOAD = 12'h010;

    // Literal group, upper byte
    localparam logic [7:0] ENC_LIT_ADD = 8'h0f;
    localparam logic [7:0] ENC_LIT_SUB = 8'h08;
    localparam logic [7:0] ENC_LIT_AND = 8'h0b;
    localparam logic [7:0] ENC_LIT_OR = 8'h09;
    localparam logic [7:0] ENC_LIT_XOR = 8'h0a;
    localparam logic [7:0] ENC_LIT_LOAD = 8'h0e;
    localparam logic [7:0] ENC_LIT_MUL = 8'h0d;
    localparam logic [7:0] ENC_LIT_RET = 8'h0c;

    // Control words with a zero upper byte, low byte
    localparam logic [7:0] ENC_NOP = 8'h00;
    localparam logic [7:0] ENC_SLEEP = 8'h03;
    localparam logic [7:0] ENC_WDT_CLR = 8'h04;
    localparam logic [7:0] ENC_PUSH = 8'h05;
    localparam logic [7:0] ENC_POP = 8'h06;
    localparam logic [7:0] ENC_DEC_ADJ = 8'h07;
    localparam logic [7:0] ENC_SW_RESET = 8'hff;
    localparam logic [5:0] ENC_TBL_READ = 6'h02;
    localparam logic [5:0] ENC_TBL_WRITE = 6'h03;
    localparam logic [6:0] ENC_INT_RET = 7'h08;
    localparam logic [6:0] ENC_SUB_RET = 7'h09;

    // Cycle counts
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_PROGRAM_TABLE_WRITE_LONG = 3'h5;
    localparam logic [2:0] HOLD_CYCLES = CYC_PROGRAM_TABLE_WRITE_LONG - CYC_TWO;

    typedef struct packed {
        logic carry;
        logic digitCarry;
        logic zero;
        logic overflow;
        logic negative;
    } cltd_flags_t;

    // Flag update masks
    localparam cltd_flags_t FLAGS_NONE = 5'h00;
    localparam cltd_flags_t FLAGS_ALL = 5'h1f;
    localparam cltd_flags_t FLAGS_LOGIC = 5'h05;
    localparam cltd_flags_t FLAGS_CARRY = 5'h10;

    typedef enum logic [4:0] {
        OP_NOP, OP_BRANCH, OP_REL_JUMP, OP_REL_CALL, OP_ABS_CALL, OP_ABS_JUMP,
        OP_POP, OP_PUSH, OP_INT_RET, OP_SUB_RET, OP_LIT_RET, OP_SLEEP,
        OP_WDT_CLR, OP_DEC_ADJ, OP_SW_RESET, OP_LIT_ADD, OP_LIT_SUB, OP_LIT_AND,
        OP_LIT_OR, OP_LIT_XOR, OP_LIT_LOAD, OP_LIT_MUL, OP_BANK_LOAD, OP_PTR_LOAD,
        OP_TBL_READ, OP_TBL_WRITE
    } cltd_op_t;

    typedef enum {ST_EXEC, ST_WORD2, ST_FLUSH, ST_HOLD} cltd_state_t;

    typedef struct packed {
        cltd_op_t op;
        logic [7:0] literal;
        logic pcLoad;
        logic [10:0] relOffset;
        logic [19:0] absTarget;
        logic fastReturn;
        cltd_flags_t flagUpd;
        logic toPdUpd;
        logic intEnUpd;
        logic [1:0] pointerSel;
        logic [11:0] pointerLit;
        logic [1:0] tableMode;
    } cltd_ctrl_t;

endpackage : cltd_pkg

// File: cltd_cond_eval.sv
`timescale 1ns/10ps
module cltd_cond_eval (
    // Condition code and flags
    input wire logic [2:0] condCode,
    input wire cltd_pkg::cltd_flags_t flags,
    // Result
    output logic taken
);

    // Even codes test the flag set, odd codes test it clear
    logic flagSel;

    always_comb begin
        unique case (condCode[2:1])
            2'h0: flagSel = flags.zero;
            2'h1: flagSel = flags.carry;
            2'h2: flagSel = flags.overflow;
            2'h3: flagSel = flags.negative;
        endcase
    end

    assign taken = flagSel ^ condCode[0];

endmodule : cltd_cond_eval

// File: cltd_decoder_tb.sv
`timescale 1ns/10ps
module cltd_decoder_tb;
    // Clock, reset and stimulus
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic instrValid = 1'b0;
    cltd_pkg::cltd_flags_t statusFlags = 5'h00;
    logic writeCycleStart = 1'b0;
    logic writeCycleDone = 1'b0;
    logic rmwTargetIsPort = 1'b0;
    logic [7:0] portPinLevels = 8'h0f;
    logic [7:0] portLatchValue = 8'hf0;
    logic [4:0] fileOp = 5'h00;
    // Observed
    cltd_pkg::cltd_ctrl_t ctrl_r;
    logic ctrlValid_r, nopCycle_r, writeBusy_r, prescalerClear_r;
    logic [7:0] rmwSource_r;
    int miscompares = 0;
    int nTests = 0;

    always #20 sys_clk = ~sys_clk;

    cltd_decoder dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .instrWord(instrWord),
        .instrValid(instrValid), .statusFlags(statusFlags), .writeCycleStart(writeCycleStart),
        .writeCycleDone(writeCycleDone), .rmwTargetIsPort(rmwTargetIsPort),
        .portPinLevels(portPinLevels), .portLatchValue(portLatchValue),
        .fileOpMarked(fileOp[4]), .fileOpTargetsTimer(fileOp[3]), .fileOpNeedsDest(fileOp[2]),
        .fileOpDestIsFile(fileOp[1]), .prescalerOnTimer(fileOp[0]), .ctrl_r(ctrl_r),
        .ctrlValid_r(ctrlValid_r), .nopCycle_r(nopCycle_r), .writeBusy_r(writeBusy_r),
        .rmwSource_r(rmwSource_r), .prescalerClear_r(prescalerClear_r));

    task automatic results();
        if (miscompares == 0 && nTests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chkBit(input logic got, input logic exp, input string msg);
        nTests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %b", $time, msg, got);
        end
    endtask : chkBit

    task automatic chkVal(input logic [19:0] got, input logic [19:0] exp, input string msg);
        nTests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chkVal

    // Present one word at an edge, settle at the next falling edge
    task automatic step(input logic [15:0] w);
        @(posedge sys_clk);
        instrWord <= w;
        instrValid <= 1'b1;
        @(negedge sys_clk);
    endtask : step

    task automatic one(input logic [15:0] w, input cltd_pkg::cltd_op_t op, input logic extra,
            input cltd_pkg::cltd_flags_t flg);
        step(w);
        step(16'h0000);
        chkBit(ctrlValid_r, 1'b1, "valid");
        chkVal(20'(ctrl_r.op), 20'(op), "op");
        chkVal(20'(ctrl_r.flagUpd), 20'(flg), "flags");
        chkBit(ctrl_r.toPdUpd, op inside {cltd_pkg::OP_SLEEP, cltd_pkg::OP_WDT_CLR}, "topd");
        chkBit(ctrl_r.intEnUpd, op == cltd_pkg::OP_INT_RET, "inten");
        if (op == cltd_pkg::OP_LIT_RET || (op >= cltd_pkg::OP_LIT_ADD && op <= cltd_pkg::OP_LIT_MUL))
            chkVal(20'(ctrl_r.literal), 20'(w[7:0]), "literal");
        if (op inside {cltd_pkg::OP_TBL_READ, cltd_pkg::OP_TBL_WRITE})
            chkVal(20'(ctrl_r.tableMode), 20'(w[1:0]), "mode");
        if (op inside {cltd_pkg::OP_REL_JUMP, cltd_pkg::OP_REL_CALL})
            chkVal(20'(ctrl_r.relOffset), 20'(w[10:0]), "offset");
        if (op inside {cltd_pkg::OP_INT_RET, cltd_pkg::OP_SUB_RET})
            chkBit(ctrl_r.fastReturn, w[0], "fast");
        if (op == cltd_pkg::OP_BANK_LOAD)
            chkVal(20'(ctrl_r.literal), 20'(w[3:0]), "bank");
        chkBit(ctrl_r.pcLoad, extra && !(op inside {cltd_pkg::OP_TBL_READ,
            cltd_pkg::OP_TBL_WRITE}), "pcload");
        step(16'h0000);
        chkBit(nopCycle_r, extra, "nop");
        chkBit(ctrlValid_r, !extra, "next");
    endtask : one

    task automatic two(input logic [15:0] w1, input logic [15:0] w2,
            input cltd_pkg::cltd_op_t op, input logic extra);
        step(w1);
        step(w2);
        chkBit(ctrlValid_r, 1'b0, "word1");
        step(16'h0000);
        chkBit(ctrlValid_r, 1'b1, "word2");
        chkVal(20'(ctrl_r.op), 20'(op), "op");
        chkBit(ctrl_r.pcLoad, extra, "pcload");
        if (op == cltd_pkg::OP_PTR_LOAD) begin
            chkVal(20'(ctrl_r.pointerSel), 20'(w1[5:4]), "ptrsel");
            chkVal(20'(ctrl_r.pointerLit), 20'({w1[3:0], w2[7:0]}), "ptrlit");
        end else begin
            chkVal(ctrl_r.absTarget, {w2[11:0], w1[7:0]}, "target");
        end
        if (op == cltd_pkg::OP_ABS_CALL)
            chkBit(ctrl_r.fastReturn, w1[8], "fast");
        step(16'h0000);
        chkBit(nopCycle_r, 1'b0, "nop");
        chkBit(ctrlValid_r, 1'b1, "next");
    endtask : two

    task automatic branches();
        logic tk;
        logic [4:0] sel;
        for (int i = 0; i < 16; i++) begin
            sel = (i[2:1] == 2'h0) ? 5'h04 : (i[2:1] == 2'h1) ? 5'h10 :
                  (i[2:1] == 2'h2) ? 5'h02 : 5'h01;
            tk = i[3] ^ i[0];
            @(posedge sys_clk);
            statusFlags <= i[3] ? sel : ~sel;
            instrWord <= {5'h1c, 3'(i), 8'h85};
            instrValid <= 1'b1;
            @(negedge sys_clk);
            step(16'h0000);
            chkVal(20'(ctrl_r.op), 20'(cltd_pkg::OP_BRANCH), "op");
            chkBit(ctrl_r.pcLoad, tk, "taken");
            chkVal(20'(ctrl_r.relOffset), 20'h00785, "offset");
            step(16'h0000);
            chkBit(nopCycle_r, tk, "nop");
            chkBit(ctrlValid_r, !tk, "next");
        end
    endtask : branches

    task automatic longWrite(input logic midReset);
        int n;
        @(posedge sys_clk);
        instrWord <= 16'h000d;
        instrValid <= 1'b1;
        writeCycleStart <= 1'b1;
        @(posedge sys_clk);
        instrWord <= 16'h0000;
        writeCycleStart <= 1'b0;
        @(negedge sys_clk);
        chkBit(writeBusy_r, 1'b1, "busy");
        if (midReset) begin
            @(posedge sys_clk);
            rst_n <= 1'b0;
            instrValid <= 1'b0;
            @(negedge sys_clk);
            chkBit(writeBusy_r, 1'b0, "rst busy");
            chkBit(nopCycle_r, 1'b0, "rst nop");
            @(posedge sys_clk);
            rst_n <= 1'b1;
            return;
        end
        chkBit(ctrlValid_r, 1'b1, "valid");
        for (int i = 0; i < 4; i++) begin
            step(16'h0000);
            chkBit(nopCycle_r, 1'b1, "hold");
        end
        n = 0;
        while (ctrlValid_r !== 1'b1 && n < 3) begin
            step(16'h0000);
            n++;
        end
        if (ctrlValid_r !== 1'b1) begin
            miscompares++;
            results();
        end
        repeat (3) step(16'h0000);
        chkBit(writeBusy_r, 1'b1, "held");
        @(posedge sys_clk);
        writeCycleDone <= 1'b1;
        @(posedge sys_clk);
        writeCycleDone <= 1'b0;
        @(negedge sys_clk);
        chkBit(writeBusy_r, 1'b0, "done");
    endtask : longWrite

    task automatic sideEffects();
        for (int i = 0; i < 32; i++) begin
            @(posedge sys_clk);
            fileOp <= 5'(i);
            rmwTargetIsPort <= i[0] ^ i[1];
            portPinLevels <= 8'(i) ^ 8'h5a;
            portLatchValue <= ~8'(i);
            @(posedge sys_clk);
            @(negedge sys_clk);
            chkBit(prescalerClear_r, i[4] & i[3] & (~i[2] | i[1]) & i[0], "pscl");
            chkVal(20'(rmwSource_r), 20'((i[0] ^ i[1]) ? 8'(i) ^ 8'h5a : 8'(~i)), "rmw");
        end
    endtask : sideEffects

    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chkBit(ctrlValid_r, 1'b0, "reset");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        one(16'h0000, cltd_pkg::OP_NOP, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'hf123, cltd_pkg::OP_NOP, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0006, cltd_pkg::OP_POP, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0005, cltd_pkg::OP_PUSH, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0011, cltd_pkg::OP_INT_RET, 1'b1, cltd_pkg::FLAGS_NONE);
        one(16'h0012, cltd_pkg::OP_SUB_RET, 1'b1, cltd_pkg::FLAGS_NONE);
        one(16'h0c5a, cltd_pkg::OP_LIT_RET, 1'b1, cltd_pkg::FLAGS_NONE);
        one(16'h0003, cltd_pkg::OP_SLEEP, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0004, cltd_pkg::OP_WDT_CLR, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0007, cltd_pkg::OP_DEC_ADJ, 1'b0, cltd_pkg::FLAGS_CARRY);
        one(16'h00ff, cltd_pkg::OP_SW_RESET, 1'b0, cltd_pkg::FLAGS_ALL);
        one(16'h0f33, cltd_pkg::OP_LIT_ADD, 1'b0, cltd_pkg::FLAGS_ALL);
        one(16'h08cc, cltd_pkg::OP_LIT_SUB, 1'b0, cltd_pkg::FLAGS_ALL);
        one(16'h0b0f, cltd_pkg::OP_LIT_AND, 1'b0, cltd_pkg::FLAGS_LOGIC);
        one(16'h09f0, cltd_pkg::OP_LIT_OR, 1'b0, cltd_pkg::FLAGS_LOGIC);
        one(16'h0aa5, cltd_pkg::OP_LIT_XOR, 1'b0, cltd_pkg::FLAGS_LOGIC);
        one(16'h0e3c, cltd_pkg::OP_LIT_LOAD, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0d81, cltd_pkg::OP_LIT_MUL, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'h0107, cltd_pkg::OP_BANK_LOAD, 1'b0, cltd_pkg::FLAGS_NONE);
        one(16'hd7ff, cltd_pkg::OP_REL_JUMP, 1'b1, cltd_pkg::FLAGS_NONE);
        one(16'hd801, cltd_pkg::OP_REL_CALL, 1'b1, cltd_pkg::FLAGS_NONE);
        for (int m = 0; m < 4; m++) begin
            one(16'h0008 | 16'(m), cltd_pkg::OP_TBL_READ, 1'b1, cltd_pkg::FLAGS_NONE);
            one(16'h000c | 16'(m), cltd_pkg::OP_TBL_WRITE, 1'b1, cltd_pkg::FLAGS_NONE);
        end
        chkBit(writeBusy_r, 1'b0, "idle");
        two(16'hec12, 16'hf345, cltd_pkg::OP_ABS_CALL, 1'b1);
        two(16'hed56, 16'hf789, cltd_pkg::OP_ABS_CALL, 1'b1);
        two(16'hefa5, 16'hfc3e, cltd_pkg::OP_ABS_JUMP, 1'b1);
        two(16'hee25, 16'hf0ab, cltd_pkg::OP_PTR_LOAD, 1'b0);
        branches();
        longWrite(1'b0);
        longWrite(1'b1);
        one(16'h0e7e, cltd_pkg::OP_LIT_LOAD, 1'b0, cltd_pkg::FLAGS_NONE);
        sideEffects();
        results();
    end
endmodule : cltd_decoder_tb
